// ### verilog/ppeq_pkg.sv
// Purpose: constants for the port police / egress queue control bank
// Assumes: 12-bit byte offsets inside one port block
// Notes: offsets are byte addresses of aligned words, save the queue index byte at 903
package ppeq_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] PPEQ_POLICE_OFS = 12'h80C;
   localparam logic [11:0] PPEQ_READOUT_OFS = 12'h810;
   localparam logic [11:0] PPEQ_QIDX_OFS = 12'h900;
   localparam logic [11:0] PPEQ_QIDX_BYTE_OFS = 12'h903;
   localparam logic [11:0] PPEQ_VID_OFS = 12'h904;
   localparam logic [11:0] PPEQ_QCTRL0_OFS = 12'h914;
   // ----------------------------------------------------------------
   // police control fields
   // ----------------------------------------------------------------
   localparam int PPEQ_DROP_COLOR_BIT = 11;
   localparam int PPEQ_DROP_ALL_BIT = 10;
   localparam int PPEQ_PKT_TYPE_LSB = 8;
   localparam int PPEQ_PORT_POL_BIT = 7;
   localparam int PPEQ_NONIP_LSB = 5;
   localparam int PPEQ_MARK_BIT = 4;
   localparam int PPEQ_REMAP_BIT = 3;
   localparam int PPEQ_DROP_SRP_BIT = 2;
   localparam int PPEQ_MODE_BIT = 1;
   localparam int PPEQ_EN_BIT = 0;
   localparam logic [11:0] PPEQ_POLICE_RST = 12'h020;
   // ----------------------------------------------------------------
   // egress fields and codes
   // ----------------------------------------------------------------
   localparam logic [1:0] PPEQ_QIDX_RST = 2'h0;
   localparam logic PPEQ_VID_RST = 1'b0;
   localparam int PPEQ_SCHED_LSB = 6;
   localparam int PPEQ_SHAPER_LSB = 4;
   localparam logic [1:0] PPEQ_SCHED_STRICT = 2'h0;
   localparam logic [1:0] PPEQ_SCHED_WRR = 2'h2;
   localparam logic [1:0] PPEQ_SHAPER_NONE = 2'h0;
   localparam logic [1:0] PPEQ_SHAPER_CBS = 2'h1;
   localparam logic [1:0] PPEQ_COLOR_GREEN = 2'h1;
   localparam int PPEQ_CNT_W = 16;
   localparam int PPEQ_WEIGHT_W = 7;
endpackage : ppeq_pkg

// ### verilog/ppeq_ctrl.sv
// Purpose: per-port police/WRED and egress queue control over APB
// Assumes: packet-side inputs come from logic on pclk
// Notes: all outputs registered; zero-wait APB slave
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps

// Functional notes
// - dropped-color bit set: color counters count only dropped packets of that color
// - drop-all set: drop everything but protected SRP packets while max WRED threshold exceeded
// - field 9:8 picks readout: 00 dropped counter, 01 green, 10 and 11 the other color counters
// - bit 7 picks per-port rate set, else port index 0 aggregate
// - non-IP frames get color from field 6:5 in color-aware mode
// - bit 4 enables DSCP color marking
// - bit 3 selects remapped color instead of raw DSCP color
// - SRP packets WRED-dropped only when bit 2 is one
// - bit 1 selects color-blind, zero selects color-aware policing
// - bit 0 enables policing and WRED together, resets off
// - queue index 1:0 selects queue of indexed registers
// - queue index also reachable as byte at offset 903
// - VID replace bit swaps non-zero VLAN ID for port default
// - with double tagging the outer tag ID is replaced
// - strict mode serves highest-numbered pending queue first
// - mode 10, reset value, gives weighted round robin
// - mode field 7:6 governs scheduling; codes 01, 11 reserved
// - shaper 00 none, 01 credit based; 10, 11 reserved
// - queue weight is packet count per turn; zero never programmed
module ppeq_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic pkt_valid,
   input wire logic pkt_is_ip,
   input wire logic pkt_is_srp,
   input wire logic [1:0] pkt_dscp_color,
   input wire logic [1:0] pkt_remap_color,
   input wire logic [1:0] pkt_port_idx,
   input wire logic pkt_wred_over,
   input wire logic pkt_prob_drop,
   output logic pol_valid,
   output logic [1:0] pol_color,
   output logic pol_drop,
   output logic pol_mark_dscp,
   output logic [1:0] pol_rate_port,
   input wire logic eg_valid,
   input wire logic eg_double_tag,
   input wire logic [11:0] eg_cvid,
   input wire logic [11:0] eg_svid,
   input wire logic [11:0] port_default_vlan_id,
   output logic eg_out_valid,
   output logic [11:0] eg_cvid_out,
   output logic [11:0] eg_svid_out,
   input wire logic [3:0] sch_pending,
   input wire logic sch_sent,
   input wire logic [27:0] queue_weight,
   output logic sch_grant_valid,
   output logic [1:0] sch_grant_q,
   output logic [3:0] sch_cbs_en
);
   import ppeq_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [1:0] hi_pend(input logic [3:0] p);
      logic [1:0] q;
      q = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (p[i]) begin
            q = 2'(i);
         end
      end
      return q;
   endfunction : hi_pend

   // first pending queue at or after s, wrapping upward
   function automatic logic [1:0] nxt_pend(input logic [3:0] p, input logic [1:0] s);
      logic [1:0] q;
      logic [1:0] c;
      logic found;
      q = s;
      found = 1'b0;
      for (int i = 0; i < 4; i++) begin
         c = s + 2'(i);
         if (p[c] && !found) begin
            q = c;
            found = 1'b1;
         end
      end
      return q;
   endfunction : nxt_pend

   // ----------------------------------------------------------------
   // registers and decode
   // ----------------------------------------------------------------
   logic [11:0] police;
   logic [1:0] qidx;
   logic vid_rep;
   logic [1:0] sched [0:3];
   logic [1:0] shaper [0:3];
   logic [PPEQ_CNT_W-1:0] cnt [0:3];
   logic [1:0] rr_q;
   logic [6:0] rr_cnt;

   wire setup = psel & ~penable;
   wire wr_acc = psel & penable & pwrite & pready;
   wire hit_pol = paddr == PPEQ_POLICE_OFS;
   wire hit_rdo = paddr == PPEQ_READOUT_OFS;
   wire hit_qidx = paddr == PPEQ_QIDX_OFS;
   wire hit_qbyte = paddr == PPEQ_QIDX_BYTE_OFS;
   wire hit_vid = paddr == PPEQ_VID_OFS;
   wire hit_qc0 = paddr == PPEQ_QCTRL0_OFS;
   wire hit_any = hit_pol | hit_rdo | hit_qidx | hit_qbyte | hit_vid | hit_qc0;

   wire [11:0] next_police = {pstrb[1] ? pwdata[11:8] : police[11:8],
                              pstrb[0] ? pwdata[7:0] : police[7:0]};
   // byte access at 903 ignores lane strobes
   wire wr_qidx = wr_acc & ((hit_qidx & pstrb[0]) | hit_qbyte);
   wire [1:0] next_qidx = pwdata[1:0];
   // reserved scheduler codes are not stored
   wire [1:0] wr_sched = pwdata[PPEQ_SCHED_LSB+:2];
   wire sched_ok = (wr_sched == PPEQ_SCHED_STRICT) | (wr_sched == PPEQ_SCHED_WRR);
   wire [1:0] next_sched = sched_ok ? wr_sched : sched[qidx];
   // reserved shaper codes are not stored
   wire [1:0] wr_shaper = pwdata[PPEQ_SHAPER_LSB+:2];
   wire shaper_ok = (wr_shaper == PPEQ_SHAPER_NONE) | (wr_shaper == PPEQ_SHAPER_CBS);
   wire [1:0] next_shaper = shaper_ok ? wr_shaper : shaper[qidx];
   wire wr_qc0 = wr_acc & hit_qc0 & pstrb[0];

   // counter readout follows packet type field
   wire [1:0] rdo_sel = police[PPEQ_PKT_TYPE_LSB+:2];
   // indexed register seen through current queue index
   wire [7:0] qc0_rd = {sched[qidx], shaper[qidx], 4'h0};
   wire [31:0] rd_word = hit_pol ? {20'h0, police} :
                         hit_rdo ? {16'h0, cnt[rdo_sel]} :
                         (hit_qidx | hit_qbyte) ? {30'h0, qidx} :
                         hit_vid ? {31'h0, vid_rep} :
                         hit_qc0 ? {24'h0, qc0_rd} : 32'h0;

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   // answer prepared in setup so pready can come from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit_any;
         prdata <= (setup & ~pwrite) ? rd_word : 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         police <= PPEQ_POLICE_RST;
         qidx <= PPEQ_QIDX_RST;
         vid_rep <= PPEQ_VID_RST;
      end else begin
         if (wr_acc & hit_pol) begin
            police <= next_police;
         end
         if (wr_qidx) begin
            qidx <= next_qidx;
         end
         if (wr_acc & hit_vid & pstrb[0]) begin
            vid_rep <= pwdata[0];
         end
      end
   end

   // every queue resets to round robin, no shaping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            sched[i] <= PPEQ_SCHED_WRR;
            shaper[i] <= PPEQ_SHAPER_NONE;
         end
      end else if (wr_qc0) begin
         sched[qidx] <= next_sched;
         shaper[qidx] <= next_shaper;
      end
   end

   // ----------------------------------------------------------------
   // policing and wred
   // ----------------------------------------------------------------
   // one enable for policing and WRED
   wire pol_en = police[PPEQ_EN_BIT];
   wire [1:0] ip_color = police[PPEQ_REMAP_BIT] ? pkt_remap_color : pkt_dscp_color;
   // non-IP frames take the configured color
   wire [1:0] aware_color = pkt_is_ip ? ip_color : police[PPEQ_NONIP_LSB+:2];
   // color blind treats every frame as green
   wire [1:0] in_color = police[PPEQ_MODE_BIT] ? PPEQ_COLOR_GREEN : aware_color;
   // drop-all over the max threshold, else probability
   wire wred_drop = (police[PPEQ_DROP_ALL_BIT] & pkt_wred_over) | pkt_prob_drop;
   wire srp_ok = ~pkt_is_srp | police[PPEQ_DROP_SRP_BIT];
   wire drop_c = pkt_valid & pol_en & srp_ok & wred_drop;
   // color counters may be limited to dropped packets
   wire cnt_col = pkt_valid & pol_en & (in_color != 2'h0) &
                  (~police[PPEQ_DROP_COLOR_BIT] | drop_c);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_valid <= 1'b0;
         pol_color <= 2'h0;
         pol_drop <= 1'b0;
         pol_mark_dscp <= 1'b0;
         pol_rate_port <= 2'h0;
      end else begin
         pol_valid <= pkt_valid;
         pol_color <= in_color;
         pol_drop <= drop_c;
         pol_mark_dscp <= pol_en & police[PPEQ_MARK_BIT];
         pol_rate_port <= police[PPEQ_PORT_POL_BIT] ? pkt_port_idx : 2'h0;
      end
   end

   // counters wrap; index 0 holds drops, 1..3 the colors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            cnt[i] <= '0;
         end
      end else begin
         if (drop_c) begin
            cnt[0] <= cnt[0] + 1'b1;
         end
         if (cnt_col) begin
            cnt[in_color] <= cnt[in_color] + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // egress vid replacement
   // ----------------------------------------------------------------
   // outer tag is the target when double tagged
   wire [11:0] tgt_vid = eg_double_tag ? eg_svid : eg_cvid;
   wire do_rep = vid_rep & (tgt_vid != 12'h0);
   wire [11:0] new_vid = do_rep ? port_default_vlan_id : tgt_vid;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eg_out_valid <= 1'b0;
         eg_cvid_out <= 12'h0;
         eg_svid_out <= 12'h0;
      end else begin
         eg_out_valid <= eg_valid;
         eg_cvid_out <= eg_double_tag ? eg_cvid : new_vid;
         eg_svid_out <= eg_double_tag ? new_vid : eg_svid;
      end
   end

   // ----------------------------------------------------------------
   // scheduler
   // ----------------------------------------------------------------
   // port policy taken from the queue 0 entry
   wire strict = sched[0] == PPEQ_SCHED_STRICT;
   wire [1:0] strict_q = hi_pend(sch_pending);
   wire [1:0] wrr_q = nxt_pend(sch_pending, rr_q);
   wire [6:0] g_weight = queue_weight[sch_grant_q*PPEQ_WEIGHT_W+:PPEQ_WEIGHT_W];
   wire [6:0] next_cnt = (sch_grant_q == rr_q) ? rr_cnt + 7'h1 : 7'h1;
   // weight reached: turn passes on; zero acts as one
   wire turn_done = next_cnt >= g_weight;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rr_q <= 2'h0;
         rr_cnt <= 7'h0;
      end else if (sch_sent & ~strict) begin
         // each queue served in turn up to its weight
         rr_q <= turn_done ? sch_grant_q + 2'h1 : sch_grant_q;
         rr_cnt <= turn_done ? 7'h0 : next_cnt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sch_grant_valid <= 1'b0;
         sch_grant_q <= 2'h0;
         sch_cbs_en <= 4'h0;
      end else begin
         sch_grant_valid <= |sch_pending;
         sch_grant_q <= strict ? strict_q : wrr_q;
         for (int i = 0; i < 4; i++) begin
            sch_cbs_en[i] <= shaper[i] == PPEQ_SHAPER_CBS;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // outputs are flops, so most checks look at the inputs of the cycle before
   a_apb_zero_wait: assert property (setup |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   a_drop_all_over: assert property ($past(pkt_valid && pol_en && srp_ok &&
      police[PPEQ_DROP_ALL_BIT] && pkt_wred_over) |-> pol_drop)
      else $error("drop-all did not drop");
   a_srp_protect: assert property (pol_drop |->
      $past(!pkt_is_srp || police[PPEQ_DROP_SRP_BIT]))
      else $error("protected SRP packet dropped");
   a_disabled_no_drop: assert property (pol_drop |-> $past(pol_en))
      else $error("drop while policing disabled");
   a_off_no_count: assert property ($past(!pol_en) |->
      $stable(cnt[0]) && $stable(cnt[1]) && $stable(cnt[2]) && $stable(cnt[3]))
      else $error("counter moved while disabled");
   a_nonip_color: assert property ($past(pkt_valid && !police[PPEQ_MODE_BIT] &&
      !pkt_is_ip) |-> pol_color == $past(police[PPEQ_NONIP_LSB+:2]))
      else $error("non-IP color wrong");
   a_remap_color: assert property ($past(pkt_valid && !police[PPEQ_MODE_BIT] &&
      pkt_is_ip && police[PPEQ_REMAP_BIT]) |-> pol_color == $past(pkt_remap_color))
      else $error("remapped color not used");
   a_blind_green: assert property ($past(pkt_valid && police[PPEQ_MODE_BIT])
      |-> pol_color == PPEQ_COLOR_GREEN)
      else $error("color blind not green");
   a_mark_enable: assert property (pol_mark_dscp ==
      $past(pol_en && police[PPEQ_MARK_BIT]))
      else $error("DSCP mark enable wrong");
   a_rate_port: assert property (pol_rate_port ==
      ($past(police[PPEQ_PORT_POL_BIT]) ? $past(pkt_port_idx) : 2'h0))
      else $error("rate set index wrong");
   a_vid_replace: assert property ($past(eg_valid && vid_rep && !eg_double_tag &&
      eg_cvid != 12'h0) |-> eg_cvid_out == $past(port_default_vlan_id))
      else $error("VID not replaced");
   a_outer_replace: assert property ($past(eg_valid && vid_rep && eg_double_tag &&
      eg_svid != 12'h0) |-> eg_svid_out == $past(port_default_vlan_id) &&
      eg_cvid_out == $past(eg_cvid))
      else $error("outer tag not replaced");
   a_strict_top: assert property ($past(strict && sch_pending[3]) |->
      sch_grant_q == 2'h3)
      else $error("strict grant not queue 3");
   a_grant_valid: assert property (sch_grant_valid == $past(|sch_pending))
      else $error("grant valid not from pending");
   a_cbs_enable: assert property (sch_cbs_en[2] == ($past(shaper[2]) == PPEQ_SHAPER_CBS))
      else $error("queue 2 shaper enable wrong");
   a_readout_sel: assert property ($past(setup && !pwrite && hit_rdo) |->
      prdata == {16'h0, $past(cnt[police[PPEQ_PKT_TYPE_LSB+:2]])})
      else $error("counter readout wrong");
   a_qidx_byte: assert property ($past(wr_acc && hit_qbyte) |->
      qidx == $past(pwdata[1:0]))
      else $error("byte write of queue index lost");
   a_drop_only_count: assert property ($past(!drop_c &&
      police[PPEQ_DROP_COLOR_BIT]) |-> $stable(cnt[1]) && $stable(cnt[2]) && $stable(cnt[3]))
      else $error("undropped packet counted");

   c_drop: cover property (pol_valid && pol_drop);
   c_wrr_turn: cover property (sch_sent && !strict && turn_done);
   c_byte_write: cover property (wr_acc && hit_qbyte);
   c_unmapped: cover property (pready && pslverr);
endmodule : ppeq_ctrl

// ### dv/test_ppeq_ctrl.sv
// Purpose: self-checking bench for the port police / egress queue control bank
// Assumes: zero-wait APB slave, datapath outputs one cycle after inputs
// Notes: random stimulus from a fixed seed, corner cases written by hand
`timescale 1ns/1ps
module test_ppeq_ctrl;
   import ppeq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [3:0] pstrb = 0;
   logic pready, pslverr, pol_valid, pol_drop, pol_mark_dscp, eg_out_valid, sch_grant_valid;
   logic [31:0] prdata;
   logic pkt_valid = 0, pkt_is_ip = 0, pkt_is_srp = 0, pkt_wred_over = 0, pkt_prob_drop = 0;
   logic [1:0] pkt_dscp_color = 0, pkt_remap_color = 0, pkt_port_idx = 0;
   logic [1:0] pol_color, pol_rate_port, sch_grant_q;
   logic eg_valid = 0, eg_double_tag = 0, sch_sent = 0;
   logic [11:0] eg_cvid = 0, eg_svid = 0, port_default_vlan_id = 0, eg_cvid_out, eg_svid_out;
   logic [3:0] sch_pending = 0, sch_cbs_en;
   logic [27:0] queue_weight = 0;
   int fail_count = 0, total_checks = 0;
   ppeq_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_is_ip(pkt_is_ip),
      .pkt_is_srp(pkt_is_srp), .pkt_dscp_color(pkt_dscp_color),
      .pkt_remap_color(pkt_remap_color), .pkt_port_idx(pkt_port_idx),
      .pkt_wred_over(pkt_wred_over), .pkt_prob_drop(pkt_prob_drop), .pol_valid(pol_valid),
      .pol_color(pol_color), .pol_drop(pol_drop), .pol_mark_dscp(pol_mark_dscp),
      .pol_rate_port(pol_rate_port), .eg_valid(eg_valid), .eg_double_tag(eg_double_tag),
      .eg_cvid(eg_cvid), .eg_svid(eg_svid), .port_default_vlan_id(port_default_vlan_id),
      .eg_out_valid(eg_out_valid), .eg_cvid_out(eg_cvid_out), .eg_svid_out(eg_svid_out),
      .sch_pending(sch_pending), .sch_sent(sch_sent), .queue_weight(queue_weight),
      .sch_grant_valid(sch_grant_valid), .sch_grant_q(sch_grant_q), .sch_cbs_en(sch_cbs_en));
   always #12.5 pclk = ~pclk;
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task check(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : check
   // answer taken at the rising edge that sees pready high, released right after it
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t: no pready", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] rd;
      logic e;
      apb(1, a, d, s, rd, e);
   endtask : wr
   task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr, input string m);
      logic [31:0] rd;
      logic e;
      apb(0, a, 0, 4'hF, rd, e);
      check(rd, exp, m);
      check({31'h0, e}, {31'h0, eerr}, m);
   endtask : rd_chk
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   function logic [1:0] exp_color(logic [11:0] c, logic ip, logic [1:0] dc, logic [1:0] rc);
      return c[1] ? PPEQ_COLOR_GREEN : (!ip ? c[6:5] : (c[3] ? rc : dc));
   endfunction : exp_color
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   logic [11:0] cfg;
   logic [1:0] col, cur;
   logic drp, rep;
   logic [15:0] cnt [4];
   logic [6:0] w [4];
   int sent;
   initial begin
      void'($urandom(32'h3a34));
      cnt = '{default: 0};
      repeat (20) @(posedge pclk);
      presetn <= 1;
      rd_chk(PPEQ_POLICE_OFS, 32'h20, 0, "police reset");
      rd_chk(PPEQ_VID_OFS, 0, 0, "vid reset");
      rd_chk(12'h000, 0, 1, "unmapped");
      for (int q = 0; q < 4; q++) begin
         wr(PPEQ_QIDX_OFS, q, 4'h1);
         rd_chk(PPEQ_QCTRL0_OFS, 32'h80, 0, "qctrl reset");
      end
      wr(PPEQ_QIDX_BYTE_OFS, 32'h2, 4'h0);
      rd_chk(PPEQ_QIDX_OFS, 2, 0, "qidx word");
      rd_chk(PPEQ_QIDX_BYTE_OFS, 2, 0, "qidx byte");
      wr(PPEQ_QCTRL0_OFS, 32'h50, 4'h1);
      rd_chk(PPEQ_QCTRL0_OFS, 32'h90, 0, "reserved sched kept");
      wr(PPEQ_QCTRL0_OFS, 32'hFF, 4'h1);
      rd_chk(PPEQ_QCTRL0_OFS, 32'h90, 0, "reserved codes kept");
      check(sch_cbs_en, 4'b0100, "cbs only indexed queue");
      wr(PPEQ_POLICE_OFS, 32'hFFFFFFFF, 4'hF);
      rd_chk(PPEQ_POLICE_OFS, 32'hFFF, 0, "police reserved");
      wr(PPEQ_VID_OFS, 32'hFFFFFFFF, 4'hF);
      rd_chk(PPEQ_VID_OFS, 1, 0, "vid reserved");
      $display("test registers done");
      wr(PPEQ_QIDX_OFS, 0, 4'h1);
      wr(PPEQ_QCTRL0_OFS, 32'h00, 4'h1);
      for (int b = 0; b < 5; b++) begin
         cfg = 12'($urandom);
         cfg[0] = (b != 0);
         if (cfg[6:5] == 0) cfg[6:5] = 2'h3;
         rep = 1'($urandom);
         wr(PPEQ_POLICE_OFS, cfg, 4'h3);
         wr(PPEQ_VID_OFS, rep, 4'h1);
         port_default_vlan_id <= 12'($urandom);
         for (int i = 0; i < 60; i++) begin
            @(posedge pclk);
            pkt_valid <= 1; eg_valid <= 1;
            pkt_is_ip <= 1'($urandom);
            pkt_is_srp <= 1'($urandom);
            pkt_port_idx <= 2'($urandom);
            pkt_wred_over <= 1'($urandom);
            pkt_prob_drop <= 1'($urandom);
            pkt_dscp_color <= 2'($urandom_range(1, 3));
            pkt_remap_color <= 2'($urandom_range(1, 3));
            eg_double_tag <= 1'($urandom);
            sch_pending <= 4'($urandom);
            eg_cvid <= ($urandom_range(0, 3) == 0) ? 12'h000 : 12'($urandom);
            eg_svid <= ($urandom_range(0, 3) == 0) ? 12'h000 : 12'($urandom);
            @(posedge pclk);
            pkt_valid <= 0; eg_valid <= 0;
            @(negedge pclk);
            col = exp_color(cfg, pkt_is_ip, pkt_dscp_color, pkt_remap_color);
            drp = (pkt_is_srp && !cfg[2]) ? 1'b0 : (cfg[10] ? (pkt_wred_over | pkt_prob_drop)
               : pkt_prob_drop);
            check({pol_valid, pol_mark_dscp, pol_rate_port},
               {1'b1, cfg[0] & cfg[4], cfg[7] ? pkt_port_idx : 2'h0}, "mark/rate");
            if (cfg[0]) check({pol_color, pol_drop}, {col, drp}, "color/drop");
            else check(pol_drop, 0, "drop while disabled");
            if (cfg[0] && drp) cnt[0]++;
            if (cfg[0] && (!cfg[11] || drp)) cnt[col]++;
            check({eg_out_valid, eg_cvid_out, eg_svid_out}, {1'b1,
               (rep && !eg_double_tag && eg_cvid != 0) ? port_default_vlan_id : eg_cvid,
               (rep && eg_double_tag && eg_svid != 0) ? port_default_vlan_id : eg_svid},
               "vid replace");
            check(sch_grant_valid, |sch_pending, "strict valid");
            for (int q = 3; q >= 0; q--) begin
               if (sch_pending[q]) begin
                  check(sch_grant_q, q, "strict grant");
                  break;
               end
            end
         end
      end
      for (int s = 0; s < 4; s++) begin
         cfg[9:8] = 2'(s);
         wr(PPEQ_POLICE_OFS, cfg, 4'h3);
         rd_chk(PPEQ_READOUT_OFS, cnt[s], 0, "counter readout");
      end
      $display("test policing done");
      wr(PPEQ_QCTRL0_OFS, 32'h80, 4'h1);
      for (int q = 0; q < 4; q++) w[q] = 7'($urandom_range(1, 3));
      queue_weight <= {w[3], w[2], w[1], w[0]};
      sch_pending <= 4'b1011;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      // turn pointer never moved while strict, so queue 0 starts
      cur = 2'h0;
      check(sch_grant_q, cur, "wrr start");
      sent = 0;
      for (int i = 0; i < 12; i++) begin
         @(posedge pclk);
         sch_sent <= 1;
         @(posedge pclk);
         sch_sent <= 0;
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         sent++;
         if (sent >= w[cur]) begin
            sent = 0;
            do cur++; while (!sch_pending[cur]);
         end
         check(sch_grant_q, cur, "wrr grant");
      end
      $display("test scheduler done");
      wrap_up();
   end
   initial begin
      #2000000;
      fail_count++;
      wrap_up();
   end
endmodule : test_ppeq_ctrl
